// file: src/uoe_top.sv
// Notes on behaviour
// - writing one to toggle_clear resets the data toggle to zero
// - toggle_clear always reads back as zero
// - fifo_overrun_flag set when an iso packet is dropped for a full FIFO (a bulk packet gets NAK instead)
// - with double buffering, out_fifo_full only when two packets are held
// - without double buffering, out_fifo_full as soon as one packet is held
// - out_double_buffer_enable selects double buffering of the OUT FIFO
// - bulk packet received sets out_packet_ready and raises an interrupt
// - in bulk mode only, send_stall_request answers OUT with STALL, sets stall_sent_flag and interrupt
// - high byte bit 6 selects isochronous versus bulk operation
// - iso packet with CRC error still loaded, sets iso_data_error
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "uoe_regs.svh"
module uoe_top
  import uoe_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic              out_token_i,
  input  wire logic              data_end_i,
  input  wire logic              crc_err_i,
  output logic                   hs_valid_o,
  output uoe_hs_t                hs_code_o,
  output logic                   data_toggle_o,
  output logic                   out_packet_ready_o,
  output logic                   irq_o
);
  typedef struct packed {
    uoe_state_t state;
    logic       toggle;
    logic       stall_req;
    logic       stall_sent;
    logic       iso_data_error;
    logic       fifo_overrun_flag;
    logic       out_packet_ready;
    logic       dbl;
    logic       iso;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [7:0] rdata;
    logic       hs_valid;
    uoe_hs_t    hs_code;
    logic       irq;
  } uoe_st_t;

  uoe_st_t st_r;
  uoe_st_t st_nxt;

  uoe_cnt_if cif ();

  uoe_pkt_cnt u_cnt (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .cif     (cif)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  logic wr_lo;
  logic wr_hi;
  logic wr_st;
  logic wr_mk;
  logic push;
  logic pop;
  logic drop;
  logic stall_ev;
  logic pkt_ev;

  assign wr_lo = wr_i && hit(addr_i, `UOE_ADDR_CTRL_LO);
  assign wr_hi = wr_i && hit(addr_i, `UOE_ADDR_CTRL_HI);
  assign wr_st = wr_i && hit(addr_i, `UOE_ADDR_IRQ_ST);
  assign wr_mk = wr_i && hit(addr_i, `UOE_ADDR_IRQ_MSK);

  // ----------------------------------------
  // link-side packet acceptance
  // ----------------------------------------
  always_comb
  begin
    push     = 1'b0;
    drop     = 1'b0;
    stall_ev = 1'b0;
    if (out_token_i && st_r.state == UOE_ST_IDLE && st_r.stall_req && !st_r.iso)
    begin
      stall_ev = 1'b1;
    end
    if (st_r.state == UOE_ST_DATA && data_end_i)
    begin
      if (st_r.iso)
      begin
        push = !cif.full;
        drop = cif.full;
      end
      else
      begin
        push = !cif.full && !crc_err_i;
      end
    end
  end

  assign pop = (wr_lo && wdata_i[`UOE_B_FLUSH] && cif.count != `UOE_CNT_ZERO)
             || (wr_lo && !wdata_i[`UOE_B_PRDY] && st_r.out_packet_ready);

  assign cif.push = push;
  assign cif.pop  = pop;
  assign cif.dbl  = st_r.dbl;

  // ready rises when a packet waits
  assign pkt_ev = !st_r.out_packet_ready && !pop && (cif.count != `UOE_CNT_ZERO || push);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.hs_valid = 1'b0;
    st_nxt.hs_code  = UOE_HS_NONE;
    st_nxt.rdata    = `UOE_RST_BYTE;

    case (st_r.state)
      UOE_ST_IDLE:
      begin
        if (out_token_i)
        begin
          if (stall_ev)
          begin
            st_nxt.hs_valid = 1'b1;
            st_nxt.hs_code  = UOE_HS_STALL;
          end
          else
          begin
            st_nxt.state = UOE_ST_DATA;
          end
        end
      end
      UOE_ST_DATA:
      begin
        if (data_end_i)
        begin
          st_nxt.state = UOE_ST_IDLE;
          if (!st_r.iso && !crc_err_i)
          begin
            st_nxt.hs_valid = 1'b1;
            st_nxt.hs_code  = push ? UOE_HS_ACK : UOE_HS_NAK;
          end
          if (push && !st_r.iso)
          begin
            st_nxt.toggle = !st_r.toggle;
          end
        end
      end
      default:
      begin
        st_nxt.state = UOE_ST_IDLE;
      end
    endcase

    // software writes: clears first, hardware sets after so a set wins
    if (wr_lo)
    begin
      st_nxt.stall_req = wdata_i[`UOE_B_SREQ];
      if (!wdata_i[`UOE_B_SSENT])
      begin
        st_nxt.stall_sent = 1'b0;
      end
      if (!wdata_i[`UOE_B_DERR])
      begin
        st_nxt.iso_data_error = 1'b0;
      end
      if (!wdata_i[`UOE_B_FIFO_OVERRUN_FLAG])
      begin
        st_nxt.fifo_overrun_flag = 1'b0;
      end
      if (wdata_i[`UOE_B_TCLR])
      begin
        st_nxt.toggle = 1'b0;
      end
    end
    if (wr_hi)
    begin
      st_nxt.dbl = wdata_i[`UOE_B_DBL];
      st_nxt.iso = wdata_i[`UOE_B_ISO];
    end
    if (wr_st)
    begin
      st_nxt.stat = st_r.stat & ~wdata_i[2:0];
    end
    if (wr_mk)
    begin
      st_nxt.mask = wdata_i[2:0];
    end

    if (pop)
    begin
      st_nxt.out_packet_ready = 1'b0;
    end
    if (pkt_ev)
    begin
      st_nxt.out_packet_ready              = 1'b1;
      st_nxt.stat[`UOE_I_PKT]   = 1'b1;
    end
    if (stall_ev)
    begin
      st_nxt.stall_sent         = 1'b1;
      st_nxt.stat[`UOE_I_STALL] = 1'b1;
    end
    if (drop)
    begin
      st_nxt.fifo_overrun_flag              = 1'b1;
      st_nxt.stat[`UOE_I_OVR]   = 1'b1;
    end
    if (push && st_r.iso && crc_err_i)
    begin
      st_nxt.iso_data_error = 1'b1;
    end

    // ----------------------------------------
    // read data, one cycle later
    // ----------------------------------------
    if (rd_i)
    begin
      if (hit(addr_i, `UOE_ADDR_CTRL_LO))
      begin
        st_nxt.rdata[`UOE_B_SSENT] = st_r.stall_sent;
        st_nxt.rdata[`UOE_B_SREQ]  = st_r.stall_req;
        st_nxt.rdata[`UOE_B_DERR]  = st_r.iso_data_error;
        st_nxt.rdata[`UOE_B_FIFO_OVERRUN_FLAG] = st_r.fifo_overrun_flag;
        st_nxt.rdata[`UOE_B_FULL]  = cif.full;
        st_nxt.rdata[`UOE_B_PRDY]  = st_r.out_packet_ready;
        st_nxt.rdata[`UOE_B_TCLR]  = 1'b0;
      end
      else if (hit(addr_i, `UOE_ADDR_CTRL_HI))
      begin
        st_nxt.rdata[`UOE_B_DBL] = st_r.dbl;
        st_nxt.rdata[`UOE_B_ISO] = st_r.iso;
      end
      else if (hit(addr_i, `UOE_ADDR_IRQ_ST))
      begin
        st_nxt.rdata[2:0] = st_r.stat;
      end
      else if (hit(addr_i, `UOE_ADDR_IRQ_MSK))
      begin
        st_nxt.rdata[2:0] = st_r.mask;
      end
    end

    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      st_r            <= '0;
      st_r.state      <= UOE_ST_IDLE;
      st_r.stat       <= `UOE_RST_IRQ;
      st_r.mask       <= `UOE_RST_IRQ;
      st_r.rdata      <= `UOE_RST_BYTE;
      st_r.hs_code    <= UOE_HS_NONE;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o            = st_r.rdata;
  assign hs_valid_o         = st_r.hs_valid;
  assign hs_code_o          = st_r.hs_code;
  assign data_toggle_o      = st_r.toggle;
  assign out_packet_ready_o = st_r.out_packet_ready;
  assign irq_o              = st_r.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_TOGGLE_CLR: assert property (ce_i && wr_lo && wdata_i[`UOE_B_TCLR] |=> !data_toggle_o)
    else $error("toggle not cleared");
  AST_TCLR_READ: assert property (ce_i && rd_i && hit(addr_i, `UOE_ADDR_CTRL_LO) |=> !rdata_o[`UOE_B_TCLR])
    else $error("toggle clear bit read as one");
  AST_FIFO_OVERRUN_FLAG_SET: assert property (ce_i && drop |=> st_r.fifo_overrun_flag && st_r.stat[`UOE_I_OVR])
    else $error("overrun not flagged");
  AST_FULL_SGL: assert property (!st_r.dbl |-> (cif.full == (cif.count != `UOE_CNT_ZERO)))
    else $error("single buffer full flag wrong");
  AST_DBL_WR: assert property (ce_i && wr_hi |=> st_r.dbl == $past(wdata_i[`UOE_B_DBL]))
    else $error("double buffer enable not stored");
  AST_FLUSH: assert property (ce_i && wr_lo && wdata_i[`UOE_B_FLUSH] && cif.count == `UOE_CNT_ONE && !push
    |=> !out_packet_ready_o && cif.count == `UOE_CNT_ZERO)
    else $error("flush did not empty");
  AST_PKT_RDY: assert property (ce_i && push && !st_r.out_packet_ready && !pop |=> out_packet_ready_o ##1 1'b1)
    else $error("packet ready not set");
  AST_STALL: assert property (ce_i && stall_ev |=> hs_valid_o && hs_code_o == UOE_HS_STALL && st_r.stall_sent)
    else $error("stall not answered");
  AST_ISO_NOHS: assert property (ce_i && st_r.iso && st_r.state == UOE_ST_DATA && data_end_i |=> !hs_valid_o)
    else $error("handshake sent in iso mode");
  AST_ISO_DATA_ERROR: assert property (ce_i && push && st_r.iso && crc_err_i |=> st_r.iso_data_error)
    else $error("data error not set");
  AST_IRQ: assert property (irq_o == |(st_r.stat & st_r.mask))
    else $error("interrupt level mismatch");
  AST_RDATA_IDLE: assert property (ce_i && !rd_i |=> rdata_o == `UOE_RST_BYTE)
    else $error("read data held past its cycle");
  AST_BULK_NAK: assert property (ce_i && !st_r.iso && st_r.state == UOE_ST_DATA && data_end_i && !crc_err_i
    && cif.full |=> hs_valid_o && hs_code_o == UOE_HS_NAK)
    else $error("full bulk endpoint did not refuse");

  COV_BULK_ACK: cover property (hs_valid_o && hs_code_o == UOE_HS_ACK);
  COV_STALL: cover property (hs_valid_o && hs_code_o == UOE_HS_STALL);
  COV_FIFO_OVERRUN_FLAG: cover property (st_r.fifo_overrun_flag);
  COV_TWO_PKT: cover property (cif.count == `UOE_SLOTS_DBL);
  COV_ISO_DERR: cover property (st_r.iso_data_error);
endmodule : uoe_top

// file: inc/uoe_regs.svh
`ifndef UOE_REGS_SVH
`define UOE_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UOE_ADDR_CTRL_LO 8'h14
`define UOE_ADDR_CTRL_HI 8'h15
`define UOE_ADDR_IRQ_ST  8'h16
`define UOE_ADDR_IRQ_MSK 8'h17
// ----------------------------------------
// low control byte fields
// ----------------------------------------
`define UOE_B_TCLR   7
`define UOE_B_SSENT  6
`define UOE_B_SREQ   5
`define UOE_B_FLUSH  4
`define UOE_B_DERR   3
`define UOE_B_FIFO_OVERRUN_FLAG  2
`define UOE_B_FULL   1
`define UOE_B_PRDY   0
// ----------------------------------------
// high control byte fields
// ----------------------------------------
`define UOE_B_DBL    7
`define UOE_B_ISO    6
// ----------------------------------------
// interrupt status / mask fields
// ----------------------------------------
`define UOE_I_PKT    0
`define UOE_I_STALL  1
`define UOE_I_OVR    2
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define UOE_RST_BYTE 8'h00
`define UOE_RST_IRQ  3'h0
`define UOE_SLOTS_DBL 2'h2
`define UOE_SLOTS_SGL 2'h1
`define UOE_CNT_ZERO  2'h0
`define UOE_CNT_ONE   2'h1
`endif

// file: inc/uoe_pkg.sv
package uoe_pkg;
  typedef enum logic [1:0] {
    UOE_HS_NONE  = 2'h0,
    UOE_HS_ACK   = 2'h1,
    UOE_HS_NAK   = 2'h2,
    UOE_HS_STALL = 2'h3
  } uoe_hs_t;
  typedef enum logic [1:0] {
    UOE_ST_IDLE = 2'b01,
    UOE_ST_DATA = 2'b10
  } uoe_state_t;
endpackage : uoe_pkg

// file: inc/uoe_cnt_if.sv
`timescale 1ns/1ps
interface uoe_cnt_if;
  logic       push;
  logic       pop;
  logic       dbl;
  logic [1:0] count;
  logic       full;
  modport ctl (output push, output pop, output dbl, input count, input full);
  modport cnt (input push, input pop, input dbl, output count, output full);
endinterface : uoe_cnt_if

// file: src/uoe_pkt_cnt.sv
`timescale 1ns/1ps
`include "uoe_regs.svh"
module uoe_pkt_cnt
  import uoe_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  uoe_cnt_if.cnt    cif
);
  typedef struct packed {
    logic [1:0] count;
  } uoe_cnt_st_t;

  uoe_cnt_st_t st_r;
  uoe_cnt_st_t st_nxt;

  // ----------------------------------------
  // packet occupancy
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (cif.push && !cif.pop)
    begin
      st_nxt.count = st_r.count + `UOE_CNT_ONE;
    end
    else if (cif.pop && !cif.push && st_r.count != `UOE_CNT_ZERO)
    begin
      st_nxt.count = st_r.count - `UOE_CNT_ONE;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      st_r <= '{count: `UOE_CNT_ZERO};
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign cif.count = st_r.count;
  assign cif.full  = cif.dbl ? (st_r.count >= `UOE_SLOTS_DBL) : (st_r.count >= `UOE_SLOTS_SGL);

  AST_FULL_DBL: assert property (@(posedge clock_i) disable iff (rst_i)
    cif.dbl |-> (cif.full == (st_r.count == `UOE_SLOTS_DBL)))
    else $error("full flag wrong with double buffering");
endmodule : uoe_pkt_cnt

// file: bench/uoe_host_model.sv
`timescale 1ns/1ps
module uoe_host_model
  import uoe_pkg::*;
(
  input  wire logic    clock_i,
  input  wire logic    hs_valid_i,
  input  wire uoe_hs_t hs_code_i,
  output logic         out_token_o,
  output logic         data_end_o,
  output logic         crc_err_o
);
  int      hs_seen;
  uoe_hs_t hs_last;
  initial
  begin
    out_token_o = 1'b0;
    data_end_o  = 1'b0;
    crc_err_o   = 1'b0;
    hs_seen     = 0;
    hs_last     = UOE_HS_NONE;
  end
  // ----------------------------------------
  // handshake capture
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    if (hs_valid_i === 1'b1)
    begin
      hs_seen <= hs_seen + 1;
      hs_last <= hs_code_i;
    end
  end
  // ----------------------------------------
  // token and data phase
  // ----------------------------------------
  task automatic send(input logic crc, input logic data, input int gap);
    @(posedge clock_i) out_token_o <= 1'b1;
    @(posedge clock_i) out_token_o <= 1'b0;
    repeat (gap) @(posedge clock_i) crc_err_o <= ~crc_err_o;
    if (data)
    begin
      @(posedge clock_i) crc_err_o <= crc;
      data_end_o <= 1'b1;
      @(posedge clock_i) data_end_o <= 1'b0;
      crc_err_o <= ~crc;
    end
  endtask : send
endmodule : uoe_host_model

// file: bench/uoe_top_tb_top.sv
`timescale 1ns/1ps
`include "uoe_regs.svh"
module uoe_top_tb_top
  import uoe_pkg::*;
;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        ce    = 1'b1;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic [31:0] seed  = 32'h00005cab;
  logic [31:0] r;
  logic        tok, dend, crc, hsv, tgl_o, prdy_o, irq;
  uoe_hs_t     hsc;
  uoe_hs_t     hsl   = UOE_HS_NONE;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cnt = 0, dbl = 0, iso = 0, tgl = 0, ssent = 0, sreq = 0;
  int          derr = 0, ovr = 0, ist = 0, imsk = 0, hsn = 0;

  always #20 clk = ~clk;

  uoe_top u_dut (
    .clock_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .out_token_i(tok), .data_end_i(dend),
    .crc_err_i(crc), .hs_valid_o(hsv), .hs_code_o(hsc), .data_toggle_o(tgl_o),
    .out_packet_ready_o(prdy_o), .irq_o(irq)
  );
  uoe_host_model u_host (
    .clock_i(clk), .hs_valid_i(hsv), .hs_code_i(hsc),
    .out_token_o(tok), .data_end_o(dend), .crc_err_o(crc)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt_rand
  function automatic int full();
    return int'(cnt >= (dbl != 0 ? 2 : 1));
  endfunction : full
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic mpop();
    if (cnt > 0)
    begin
      cnt--;
      if (cnt > 0)
        ist |= 1;
    end
  endtask : mpop
  task automatic wlo(input int tclr, input int fl, input int unl, input int keep);
    wreg(`UOE_ADDR_CTRL_LO, 8'((tclr << 7) | (keep * 'h4c) | (sreq << 5) | (fl << 4) | (unl == 0)));
    if (tclr != 0)
      tgl = 0;
    if (keep == 0)
    begin
      ssent = 0;
      derr  = 0;
      ovr   = 0;
    end
    if (fl != 0 || unl != 0)
      mpop();
  endtask : wlo
  task automatic pkt(input logic c, input int gap);
    if (sreq != 0 && iso == 0)
    begin
      u_host.send(1'b0, 1'b0, gap);
      hsn++;
      hsl   = UOE_HS_STALL;
      ssent = 1;
      ist  |= 2;
    end
    else
    begin
      u_host.send(c, 1'b1, gap);
      if (iso != 0 && full() != 0)
      begin
        ovr  = 1;
        ist |= 4;
      end
      else if (iso != 0 || !c)
      begin
        if (iso == 0)
          hsn++;
        if (iso == 0)
          hsl = full() != 0 ? UOE_HS_NAK : UOE_HS_ACK;
        if (iso != 0)
          derr |= int'(c);
        if (iso == 0 && full() == 0)
          tgl ^= 1;
        if (cnt == 0)
          ist |= 1;
        if (iso != 0 || full() == 0)
          cnt++;
      end
    end
  endtask : pkt
  task automatic cmp_all();
    repeat (3) @(posedge clk);
    rreg(`UOE_ADDR_CTRL_LO, rv);
    chk(rv, 8'((ssent << 6) | (sreq << 5) | (derr << 3) | (ovr << 2) | (full() << 1) | (cnt > 0)), "low");
    rreg(`UOE_ADDR_IRQ_ST, rv);
    chk(rv, 8'(ist), "status");
    chk({7'h0, tgl_o}, 8'(tgl), "toggle");
    chk({7'h0, prdy_o}, 8'(cnt > 0), "ready");
    chk({7'h0, irq}, 8'((ist & imsk) != 0), "irq");
    chk(8'(u_host.hs_seen), 8'(hsn), "hs count");
    chk({6'h0, u_host.hs_last}, {6'h0, hsl}, "hs code");
  endtask : cmp_all
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 'h14; a < 'h18; a++)
    begin
      rreg(8'(a), rv);
      chk(rv, 8'h00, "reset value");
    end
    wreg(8'h20, 8'hff);
    rreg(8'h20, rv);
    chk(rv, 8'h00, "unmapped");
    for (int i = 0; i < 120; i++)
    begin
      r = nxt_rand();
      case (r[2:0])
        3'h0, 3'h1, 3'h2: pkt(r[4] & r[7], int'(r[6:5]));
        3'h3: wlo(0, 0, 1, 1);
        3'h4: wlo(0, 1, 0, 1);
        3'h5:
        begin
          sreq = int'(r[4] & r[5]);
          wlo(int'(r[6]), 0, 0, int'(r[7]));
        end
        3'h6:
        begin
          dbl = int'(r[4]);
          iso = int'(r[5] & r[8]);
          wreg(`UOE_ADDR_CTRL_HI, {r[4], r[5] & r[8], 6'h3f});
          rreg(`UOE_ADDR_CTRL_HI, rv);
          chk(rv, 8'((dbl << 7) | (iso << 6)), "high");
        end
        default:
        begin
          imsk = int'(r[6:4]);
          wreg(`UOE_ADDR_IRQ_MSK, {5'h00, r[6:4]});
          wreg(`UOE_ADDR_IRQ_ST, {5'h00, r[10:8]});
          ist &= ~int'(r[10:8]);
          rreg(`UOE_ADDR_IRQ_MSK, rv);
          chk(rv, 8'(imsk), "mask");
        end
      endcase
      cmp_all();
    end
    // a write while the clock enable is low is lost
    @(posedge clk);
    ce <= 1'b0;
    wreg(`UOE_ADDR_CTRL_HI, {~dbl[0], ~iso[0], 6'h00});
    ce <= 1'b1;
    rreg(`UOE_ADDR_CTRL_HI, rv);
    chk(rv, 8'((dbl << 7) | (iso << 6)), "frozen");
    final_report();
  end
  initial
  begin
    #800000;
    fail_count++;
    final_report();
  end
endmodule : uoe_top_tb_top
